// ===== include/twb_pkg.sv
package twb_pkg;

	localparam int VAL_W = 18;
	localparam int GT_W  = 32;
	localparam int LVL_W = 5;
	localparam int SEGS  = 20;

	localparam logic signed [VAL_W-1:0] TWB_DISP_MAX = 18'h1869f;
	localparam logic signed [VAL_W-1:0] TWB_DISP_MIN = 18'h27961;
	localparam logic signed [VAL_W-1:0] TWB_ZERO     = 18'h00000;
	localparam logic signed [VAL_W-1:0] TWB_ONE      = 18'h00001;
	localparam logic signed [VAL_W-1:0] TWB_HIGH_DEF = 18'h003e8;
	localparam logic signed [VAL_W-1:0] TWB_LOW_DEF  = 18'h00000;
	localparam logic signed [VAL_W-1:0] TWB_PRE_DEF  = 18'h00000;
	localparam logic signed [VAL_W-1:0] TWB_AUTO_DEF = 18'h00000;
	localparam logic [LVL_W-1:0] TWB_FULL = 5'h14;
	localparam logic [LVL_W-1:0] TWB_HALF = 5'h0a;
	localparam logic [LVL_W-1:0] TWB_LVL0 = 5'h00;
	localparam logic [LVL_W-1:0] TWB_LVL1 = 5'h01;
	localparam logic [LVL_W-1:0] TWB_LVL2 = 5'h02;

	typedef enum logic [1:0] {
		TWB_OP_RATE  = 2'b00,
		TWB_OP_TOTAL = 2'b01,
		TWB_OP_BOTH  = 2'b10
	} twb_op_t;

	typedef enum logic [1:0] {
		TWB_WRAP_OFF    = 2'b00,
		TWB_WRAP_ZERO   = 2'b01,
		TWB_WRAP_PRESET = 2'b10,
		TWB_WRAP_ROLL   = 2'b11
	} twb_wrap_t;

	typedef enum logic [1:0] {
		TWB_STY_BAR  = 2'b00,
		TWB_STY_DOT  = 2'b01,
		TWB_STY_DDOT = 2'b10,
		TWB_STY_CBAR = 2'b11
	} twb_style_t;

	typedef enum logic {
		TWB_SRC_RATE  = 1'b0,
		TWB_SRC_TOTAL = 1'b1
	} twb_src_t;

	typedef struct packed {
		twb_op_t                 totaliser_mode;
		twb_wrap_t               wrap_operation_select;
		logic signed [VAL_W-1:0] preset_value;
		logic                    auto_reset_on;
		logic signed [VAL_W-1:0] auto_reset_value;
		logic                    reset_to_preset;
		twb_src_t                bar_source;
		twb_style_t              bar_style;
		logic signed [VAL_W-1:0] bargraph_low_limit;
		logic signed [VAL_W-1:0] bargraph_high_limit;
	} twb_cfg_t;

	localparam twb_cfg_t TWB_CFG_RESET = '{
		totaliser_mode:        TWB_OP_TOTAL,
		wrap_operation_select: TWB_WRAP_ZERO,
		preset_value:          TWB_PRE_DEF,
		auto_reset_on:         1'b0,
		auto_reset_value:      TWB_AUTO_DEF,
		reset_to_preset:       1'b0,
		bar_source:            TWB_SRC_TOTAL,
		bar_style:             TWB_STY_BAR,
		bargraph_low_limit:    TWB_LOW_DEF,
		bargraph_high_limit:   TWB_HIGH_DEF
	};

endpackage

// ===== hw/twb_totaliser_bargraph.sv
`timescale 1ns/100ps
module twb_totaliser_bargraph
	import twb_pkg::*;
(
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst_n,
	input  wire logic                    i_cfg_wr,
	input  wire twb_cfg_t                i_cfg,
	input  wire logic                    i_gt_por_clear,
	input  wire logic signed [GT_W-1:0]  i_gt_stored,
	input  wire logic                    i_count_up,
	input  wire logic                    i_count_dn,
	input  wire logic                    i_reset_total,
	input  wire logic                    i_reset_grand,
	input  wire logic signed [VAL_W-1:0] i_rate_value,
	output twb_cfg_t                     o_cfg,
	output logic signed [VAL_W-1:0]      o_total,
	output logic signed [GT_W-1:0]       o_grand_total,
	output logic                         o_auto_reset,
	output logic [SEGS-1:0]              o_segments
);

	twb_cfg_t                cfg;
	logic                    init_pending;
	logic signed [VAL_W-1:0] total;
	logic signed [VAL_W-1:0] next_total;
	logic                    next_auto;
	logic signed [GT_W-1:0]  grand;
	logic                    tot_mode;
	logic                    up_only;
	logic                    dn_only;
	logic signed [VAL_W-1:0] reload_val;
	logic signed [VAL_W-1:0] reading;
	logic [LVL_W-1:0]        level;
	logic [LVL_W-1:0]        pos_lvl;
	logic [LVL_W-1:0]        neg_lvl;
	logic [LVL_W-1:0]        dot_idx;
	logic [LVL_W-1:0]        dd_idx;
	logic [SEGS-1:0]         next_segments;

	// clamped linear scale of num/den onto 0..full
	function automatic logic [LVL_W-1:0] twb_scale(
		input logic signed [VAL_W:0] num,
		input logic signed [VAL_W:0] den,
		input logic [LVL_W-1:0]      full
	);
		logic [23:0] prod;
		logic [23:0] quo;
		prod = 24'h000000;
		quo  = 24'h000000;
		if (num <= 0 || den <= 0) begin
			twb_scale = TWB_LVL0;
		end else if (num >= den) begin
			twb_scale = full;
		end else begin
			prod = {5'h00, num[VAL_W:0]} * {19'h00000, full};
			quo  = prod / {5'h00, den[VAL_W:0]};
			twb_scale = quo[LVL_W-1:0];
		end
	endfunction

	// configuration store
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg <= TWB_CFG_RESET;
		end else if (i_cfg_wr) begin
			cfg <= i_cfg;
		end
	end

	// first cycle after release stands for power-up
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			init_pending <= 1'b1;
		end else begin
			init_pending <= 1'b0;
		end
	end

	assign tot_mode = (cfg.totaliser_mode == TWB_OP_TOTAL) ||
		(cfg.totaliser_mode == TWB_OP_BOTH);
	assign up_only = i_count_up && !i_count_dn;
	assign dn_only = i_count_dn && !i_count_up;
	assign reload_val = cfg.reset_to_preset ? cfg.preset_value
		: TWB_ZERO;

	always_comb begin
		next_total = total;
		next_auto  = 1'b0;
		if (init_pending || i_reset_total) begin
			next_total = reload_val;
		end else if (up_only) begin
			if (tot_mode && cfg.wrap_operation_select == TWB_WRAP_ROLL
				&& total >= TWB_DISP_MAX) begin
				next_total = TWB_ZERO;
			end else if (tot_mode && cfg.auto_reset_on
				&& (cfg.wrap_operation_select == TWB_WRAP_ZERO
				|| cfg.wrap_operation_select == TWB_WRAP_PRESET)
				&& total + TWB_ONE == cfg.auto_reset_value) begin
				next_auto = 1'b1;
				if (cfg.wrap_operation_select == TWB_WRAP_PRESET) begin
					next_total = cfg.preset_value;
				end else begin
					next_total = TWB_ZERO;
				end
			end else if (total < TWB_DISP_MAX) begin
				next_total = total + TWB_ONE;
			end
		end else if (dn_only) begin
			if (tot_mode && cfg.wrap_operation_select == TWB_WRAP_ROLL
				&& total <= TWB_ZERO) begin
				next_total = TWB_DISP_MAX;
			end else if (total > TWB_DISP_MIN) begin
				next_total = total - TWB_ONE;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			total        <= TWB_ZERO;
			o_auto_reset <= 1'b0;
		end else begin
			total        <= next_total;
			o_auto_reset <= next_auto;
		end
	end

	// grand total: cleared or restored at power-up
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			grand <= '0;
		end else if (init_pending) begin
			grand <= i_gt_por_clear ? '0 : i_gt_stored;
		end else if (i_reset_grand) begin
			grand <= '0;
		end else if (up_only) begin
			grand <= grand + 1;
		end else if (dn_only) begin
			grand <= grand - 1;
		end
	end

	// bargraph level
	assign reading = (cfg.bar_source == TWB_SRC_TOTAL) ? total
		: i_rate_value;

	always_comb begin
		level = twb_scale(
			(VAL_W+1)'(reading) - (VAL_W+1)'(cfg.bargraph_low_limit),
			(VAL_W+1)'(cfg.bargraph_high_limit)
				- (VAL_W+1)'(cfg.bargraph_low_limit),
			TWB_FULL);
		pos_lvl = twb_scale((VAL_W+1)'(reading),
			(VAL_W+1)'(cfg.bargraph_high_limit), TWB_HALF);
		neg_lvl = twb_scale(-(VAL_W+1)'(reading),
			-(VAL_W+1)'(cfg.bargraph_low_limit), TWB_HALF);
		dot_idx = (level == TWB_LVL0) ? TWB_LVL0 : level - TWB_LVL1;
		if (level <= TWB_LVL1) begin
			dd_idx = TWB_LVL0;
		end else if (level >= TWB_FULL) begin
			dd_idx = TWB_FULL - TWB_LVL2;
		end else begin
			dd_idx = level - TWB_LVL1;
		end
	end

	// per-segment decode
	genvar gi;
	generate
		for (gi = 0; gi < SEGS; gi++) begin : g_seg
			localparam logic [LVL_W-1:0] IDX = LVL_W'(gi);
			always_comb begin
				case (cfg.bar_style)
					TWB_STY_BAR: begin
						next_segments[gi] = IDX < level;
					end
					TWB_STY_DOT: begin
						next_segments[gi] = IDX == dot_idx;
					end
					TWB_STY_DDOT: begin
						next_segments[gi] = (IDX == dd_idx)
							|| (IDX == dd_idx + TWB_LVL1);
					end
					TWB_STY_CBAR: begin
						next_segments[gi] = (IDX >= TWB_HALF
							&& IDX < TWB_HALF + pos_lvl)
							|| (IDX < TWB_HALF
							&& IDX >= TWB_HALF - neg_lvl);
					end
					default: begin
						next_segments[gi] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_segments <= '0;
		end else begin
			o_segments <= next_segments;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_total       <= TWB_ZERO;
			o_grand_total <= '0;
			o_cfg         <= TWB_CFG_RESET;
		end else begin
			o_total       <= next_total;
			o_grand_total <= grand;
			o_cfg         <= cfg;
		end
	end

	// checks
	a_reset_load: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(init_pending || i_reset_total) |=> total == $past(reload_val))
		else $error("total not reloaded after reset");

	a_auto_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && up_only && tot_mode
		&& cfg.auto_reset_on && cfg.wrap_operation_select == TWB_WRAP_ZERO
		&& total + TWB_ONE == cfg.auto_reset_value)
		|=> total == TWB_ZERO && o_auto_reset)
		else $error("auto reset to zero missed");

	a_auto_preset: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && up_only && tot_mode
		&& cfg.auto_reset_on && cfg.wrap_operation_select == TWB_WRAP_PRESET
		&& total + TWB_ONE == cfg.auto_reset_value)
		|=> total == $past(cfg.preset_value))
		else $error("auto reset to preset missed");

	a_auto_off: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!cfg.auto_reset_on || !tot_mode) |=> !o_auto_reset)
		else $error("auto reset while disabled");

	a_roll_up: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && up_only && tot_mode
		&& cfg.wrap_operation_select == TWB_WRAP_ROLL
		&& total == TWB_DISP_MAX) |=> total == TWB_ZERO)
		else $error("no rollover at display maximum");

	a_roll_down: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && dn_only && tot_mode
		&& cfg.wrap_operation_select == TWB_WRAP_ROLL
		&& total == TWB_ZERO) |=> total == TWB_DISP_MAX)
		else $error("no rollover at zero");

	a_rate_nowrap: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!tot_mode && !init_pending && !i_reset_total && up_only
		&& total == TWB_DISP_MAX) |=> total == TWB_DISP_MAX)
		else $error("wrap acted outside total modes");

	a_gt_clear: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(init_pending && i_gt_por_clear) |=> ##1 o_grand_total == '0)
		else $error("grand total not cleared at power-up");

	a_bar_full: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_BAR && reading >= cfg.bargraph_high_limit
		&& cfg.bargraph_high_limit > cfg.bargraph_low_limit)
		|=> &o_segments)
		else $error("solid bar not full at high limit");

	a_dot_one: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		cfg.bar_style == TWB_STY_DOT |=> $onehot(o_segments))
		else $error("single dot not one segment");

	a_ddot_two: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		cfg.bar_style == TWB_STY_DDOT |=> $countones(o_segments) == 2)
		else $error("double dot not two segments");

	a_cbar_zero: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_CBAR && reading == TWB_ZERO)
		|=> o_segments == '0)
		else $error("centre bar lit at zero");

	a_plain_up: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && up_only && !tot_mode
		&& total < TWB_DISP_MAX)
		|=> total == $past(total) + TWB_ONE)
		else $error("plain up count lost");

	a_plain_down: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(!init_pending && !i_reset_total && dn_only && !tot_mode
		&& total > TWB_DISP_MIN)
		|=> total == $past(total) - TWB_ONE)
		else $error("plain down count lost");

	a_auto_up_only: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		dn_only |=> !o_auto_reset)
		else $error("auto reset on a down count");

	a_gt_keep: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(init_pending && !i_gt_por_clear)
		|=> ##1 o_grand_total == $past(i_gt_stored, 2))
		else $error("grand total not kept at power-up");

	a_bar_empty: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_BAR
		&& reading <= cfg.bargraph_low_limit) |=> o_segments == '0)
		else $error("solid bar lit below low limit");

	a_dot_top: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_DOT && reading >= cfg.bargraph_high_limit
		&& cfg.bargraph_high_limit > cfg.bargraph_low_limit)
		|=> o_segments[SEGS-1])
		else $error("single dot not at top at high limit");

	a_ddot_adj: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		cfg.bar_style == TWB_STY_DDOT
		|=> $countones(o_segments & (o_segments >> 1)) == 1)
		else $error("double dot segments not adjacent");

	a_cbar_top: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_CBAR && reading >= cfg.bargraph_high_limit
		&& cfg.bargraph_high_limit > TWB_ZERO)
		|=> &o_segments[SEGS-1:SEGS/2])
		else $error("centre bar upper half not full");

	a_cbar_bottom: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(cfg.bar_style == TWB_STY_CBAR && reading <= cfg.bargraph_low_limit
		&& cfg.bargraph_low_limit < TWB_ZERO)
		|=> &o_segments[SEGS/2-1:0])
		else $error("centre bar lower half not full");

	c_roll_up: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		up_only && tot_mode && total == TWB_DISP_MAX
		&& cfg.wrap_operation_select == TWB_WRAP_ROLL);
	c_auto_reset: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		o_auto_reset);
	c_cbar_neg: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		cfg.bar_style == TWB_STY_CBAR && reading < TWB_ZERO);
	c_preset_load: cover property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		i_reset_total && cfg.reset_to_preset);
	c_dot_mid: cover property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		cfg.bar_style == TWB_STY_DOT && level > TWB_LVL1);

endmodule // twb_totaliser_bargraph

// ===== verification/twb_pulse_src.sv
`timescale 1ns/100ps
module twb_pulse_src (
	input  wire logic i_sys_clk,
	output logic      o_count_up,
	output logic      o_count_dn
);
	initial begin
		o_count_up = 1'b0;
		o_count_dn = 1'b0;
	end

	// gap 0 gives back-to-back pulses, else idle cycles between them
	task automatic send(input logic up, input int n, input int gap);
		for (int k = 0; k < n; k++) begin
			@(posedge i_sys_clk);
			o_count_up <= up;
			o_count_dn <= ~up;
			if (gap > 0) begin
				@(posedge i_sys_clk);
				o_count_up <= 1'b0;
				o_count_dn <= 1'b0;
				repeat (gap - 1) @(posedge i_sys_clk);
			end
		end
		@(posedge i_sys_clk);
		o_count_up <= 1'b0;
		o_count_dn <= 1'b0;
	endtask
endmodule // twb_pulse_src

// ===== verification/tb_totaliser_wrap_bargraph.sv
`timescale 1ns/100ps
module tb_totaliser_wrap_bargraph import twb_pkg::*; ();
	logic                    clk     = 1'b0;
	logic                    rst_n   = 1'b0;
	logic                    cfg_wr  = 1'b0;
	twb_cfg_t                cfg     = TWB_CFG_RESET;
	twb_cfg_t                nc      = TWB_CFG_RESET;
	logic                    por_clr = 1'b0;
	logic signed [GT_W-1:0]  gt_in   = 32'h00000123;
	logic                    rst_tot = 1'b0;
	logic                    rst_gt  = 1'b0;
	logic signed [VAL_W-1:0] rate    = 18'h00000;
	logic                    up;
	logic                    dn;
	logic                    auto_rst;
	twb_cfg_t                cfg_q;
	logic signed [VAL_W-1:0] total;
	logic signed [GT_W-1:0]  gt;
	logic [SEGS-1:0]         segs;
	int                      err_count = 0;
	int                      compares  = 0;
	int                      auto_seen = 0;

	always #20 clk = ~clk;

	// tally one-cycle automatic reset pulses
	always @(posedge clk) begin
		if (auto_rst === 1'b1) begin
			auto_seen++;
		end
	end

	twb_pulse_src src (.i_sys_clk(clk), .o_count_up(up), .o_count_dn(dn));

	twb_totaliser_bargraph dut (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_cfg_wr(cfg_wr), .i_cfg(cfg),
		.i_gt_por_clear(por_clr), .i_gt_stored(gt_in), .i_count_up(up),
		.i_count_dn(dn), .i_reset_total(rst_tot), .i_reset_grand(rst_gt),
		.i_rate_value(rate), .o_cfg(cfg_q), .o_total(total),
		.o_grand_total(gt), .o_auto_reset(auto_rst), .o_segments(segs)
	);

	task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wcfg();
		@(posedge clk);
		cfg <= nc;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clk);
		rst_n <= 1'b0;
		por_clr <= strap;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		nc = TWB_CFG_RESET;
	endtask

	task automatic pulse(input logic grand);
		@(posedge clk);
		rst_tot <= ~grand;
		rst_gt <= grand;
		@(posedge clk);
		rst_tot <= 1'b0;
		rst_gt <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	// counts, then let the total settle before it is looked at
	task automatic cnt(input logic u, input int n, input int gap);
		src.send(u, n, gap);
		@(posedge clk);
		@(negedge clk);
	endtask

	task automatic bar(input twb_style_t s, input twb_src_t sr,
		input logic signed [VAL_W-1:0] r, input logic signed [VAL_W-1:0] lo,
		input logic signed [VAL_W-1:0] hi, input logic [SEGS-1:0] exp);
		nc.bar_style = s;
		nc.bar_source = sr;
		nc.bargraph_low_limit = lo;
		nc.bargraph_high_limit = hi;
		@(posedge clk);
		rate <= r;
		wcfg();
		chk(segs, exp);
	endtask

	task automatic t_reset();
		do_reset(1'b0);
		chk(gt, 32'h00000123);
		chk(total, TWB_ZERO);
		chk(cfg_q, TWB_CFG_RESET);
		pulse(1'b1);
		chk(gt, 32'h00000000);
		do_reset(1'b1);
		chk(gt, 32'h00000000);
		nc.preset_value = 18'h00007;
		nc.reset_to_preset = 1'b1;
		wcfg();
		pulse(1'b0);
		chk(total, 18'h00007);
		nc.reset_to_preset = 1'b0;
		wcfg();
		pulse(1'b0);
		chk(total, TWB_ZERO);
		$display("test reset done");
	endtask

	task automatic t_auto();
		nc.auto_reset_on = 1'b1;
		nc.auto_reset_value = 18'h00005;
		wcfg();
		cnt(1'b1, 4, 0);
		chk(total, 18'h00004);
		chk(auto_seen, 0);
		cnt(1'b1, 1, 0);
		chk(total, TWB_ZERO);
		chk(auto_seen, 1);
		cnt(1'b1, 5, 2);
		chk(total, TWB_ZERO);
		chk(auto_seen, 2);
		nc.totaliser_mode = TWB_OP_RATE;
		wcfg();
		cnt(1'b1, 5, 0);
		chk(total, 18'h00005);
		chk(auto_seen, 2);
		nc.totaliser_mode = TWB_OP_BOTH;
		nc.auto_reset_value = 18'h00008;
		wcfg();
		cnt(1'b1, 3, 0);
		chk(total, TWB_ZERO);
		chk(auto_seen, 3);
		nc.totaliser_mode = TWB_OP_TOTAL;
		nc.wrap_operation_select = TWB_WRAP_PRESET;
		nc.preset_value = 18'h00003;
		nc.auto_reset_value = 18'h00006;
		nc.reset_to_preset = 1'b1;
		wcfg();
		pulse(1'b0);
		cnt(1'b1, 3, 0);
		chk(total, 18'h00003);
		chk(auto_seen, 4);
		nc.auto_reset_on = 1'b0;
		wcfg();
		cnt(1'b1, 4, 0);
		chk(total, 18'h00007);
		chk(auto_seen, 4);
		$display("test auto reset done");
	endtask

	task automatic t_roll();
		nc.wrap_operation_select = TWB_WRAP_ROLL;
		nc.reset_to_preset = 1'b0;
		wcfg();
		pulse(1'b0);
		cnt(1'b0, 1, 0);
		chk(total, 18'h1869f);
		cnt(1'b0, 1, 0);
		chk(total, 18'h1869e);
		cnt(1'b1, 2, 0);
		chk(total, TWB_ZERO);
		cnt(1'b1, 1, 0);
		chk(total, 18'h00001);
		nc.totaliser_mode = TWB_OP_RATE;
		nc.preset_value = 18'h1869f;
		nc.reset_to_preset = 1'b1;
		wcfg();
		pulse(1'b0);
		chk(total, 18'h1869f);
		cnt(1'b1, 1, 0);
		chk(total, 18'h1869f);
		$display("test rollover done");
	endtask

	task automatic t_bar();
		nc.wrap_operation_select = TWB_WRAP_OFF;
		nc.preset_value = 18'h001f4;
		nc.reset_to_preset = 1'b1;
		wcfg();
		pulse(1'b0);
		bar(TWB_STY_BAR, TWB_SRC_TOTAL, 0, 0, 1000, 20'h003ff);
		bar(TWB_STY_DOT, TWB_SRC_TOTAL, 0, 0, 1000, 20'h00200);
		bar(TWB_STY_DDOT, TWB_SRC_TOTAL, 0, 0, 1000, 20'h00600);
		bar(TWB_STY_CBAR, TWB_SRC_TOTAL, 0, -1000, 1000, 20'h07c00);
		bar(TWB_STY_CBAR, TWB_SRC_RATE, -500, -1000, 1000, 20'h003e0);
		bar(TWB_STY_BAR, TWB_SRC_RATE, 1000, 0, 1000, 20'hfffff);
		bar(TWB_STY_BAR, TWB_SRC_RATE, 2000, 0, 1000, 20'hfffff);
		bar(TWB_STY_BAR, TWB_SRC_RATE, -5, 0, 1000, 20'h00000);
		bar(TWB_STY_BAR, TWB_SRC_RATE, 50, 0, 1000, 20'h00001);
		bar(TWB_STY_BAR, TWB_SRC_RATE, 600, 100, 1100, 20'h003ff);
		$display("test bargraph done");
	endtask

	initial begin
		t_reset();
		t_auto();
		t_roll();
		t_bar();
		give_verdict();
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		give_verdict();
	end
endmodule // tb_totaliser_wrap_bargraph
